// ==== verilog/crli_consts.svh ====
`ifndef CRLI_CONSTS_SVH
`define CRLI_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define CRLI_SP_IDX      3'h6
`define CRLI_PC_IDX      3'h7

// ----------------------------------------------------------------------
// Stack and address arithmetic
// ----------------------------------------------------------------------
`define CRLI_WORD_STEP   16'h0002
`define CRLI_EVEN_MASK   16'hfffe

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CRLI_SP_RST      16'h1000
`define CRLI_PSW_RST     16'h0000

// ----------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------
`define CRLI_PSW_MODE_HI 15
`define CRLI_PSW_MODE_LO 14
`define CRLI_PSW_RSET    11

`endif

// ==== verilog/crli_pkg.sv ====
`default_nettype none
package crli_pkg;
    typedef logic [15:0]      crli_word_t;
    typedef logic [7:0][15:0] crli_regs_t;

    typedef enum logic [1:0] {
        CRLI_OP_CALL,
        CRLI_OP_RET,
        CRLI_OP_RTI
    } crli_op_t;

    typedef enum {
        CRLI_ST_IDLE,
        CRLI_ST_CALL_PUSH,
        CRLI_ST_RET_POP,
        CRLI_ST_INT_PSW,
        CRLI_ST_INT_PC,
        CRLI_ST_VEC_PC,
        CRLI_ST_VEC_PSW,
        CRLI_ST_RTI_PC,
        CRLI_ST_RTI_PSW
    } crli_state_t;
endpackage : crli_pkg
`default_nettype wire

// ==== verilog/crli_rf_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface crli_rf_if;
    import crli_pkg::*;
    logic       pc_we;
    crli_word_t pc_d;
    logic       sp_we;
    crli_word_t sp_d;
    logic       gen_we;
    logic [2:0] gen_idx;
    crli_word_t gen_d;
    crli_regs_t regs;

    modport ctrl  (output pc_we, pc_d, sp_we, sp_d, gen_we, gen_idx, gen_d, input regs);
    modport store (input pc_we, pc_d, sp_we, sp_d, gen_we, gen_idx, gen_d, output regs);
endinterface : crli_rf_if
`default_nettype wire

// ==== verilog/crli_regfile.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "crli_consts.svh"
module crli_regfile #(
    parameter logic [15:0] SP_RESET = `CRLI_SP_RST
) (
    input  wire logic mclk_in,
    input  wire logic srst_in,
    crli_rf_if.store  rf
);
    import crli_pkg::*;

    // ------------------------------------------------------------------
    // Eight general registers, dedicated ports win over the general one
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_reg
            localparam logic [2:0] IDX = 3'(i);
            wire logic pc_hit  = rf.pc_we && (IDX == `CRLI_PC_IDX);
            wire logic sp_hit  = rf.sp_we && (IDX == `CRLI_SP_IDX);
            wire logic gen_hit = rf.gen_we && (rf.gen_idx == IDX);
            always_ff @(posedge mclk_in) begin
                if (srst_in) begin
                    rf.regs[i] <= (IDX == `CRLI_SP_IDX) ? SP_RESET : 16'h0000;
                end else if (pc_hit) begin
                    rf.regs[i] <= rf.pc_d;
                end else if (sp_hit) begin
                    rf.regs[i] <= rf.sp_d & `CRLI_EVEN_MASK;
                end else if (gen_hit) begin
                    // Stack pointer stays even even when the sequencer loads it
                    rf.regs[i] <= (IDX == `CRLI_SP_IDX) ? (rf.gen_d & `CRLI_EVEN_MASK) : rf.gen_d;
                end
            end
        end
    endgenerate
endmodule : crli_regfile
`default_nettype wire

// ==== verilog/crli_linkage.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "crli_consts.svh"
// How it works
// - A call first pushes the named linkage register onto the system stack by pre-decrement.
// - The call then loads the linkage register with the program counter and jumps to the entry.
// - Register 6 is the stack pointer for every automatic save and restore.
// - A return copies the named register into the program counter, then pops the stack into it.
// - An interrupt is taken only at an instruction boundary, after the current instruction.
// - Interrupt entry pushes the status word and then the program counter onto the stack.
// - The new program counter comes from the vector's first word, the status from the next.
// - The loaded status word sets the service routine's mode and register set selection.
// - Return from interrupt pops the program counter and then the status word.
// - Register 7 is the program counter; any register, register 7 included, may serve as linkage.
// - The system stack holds whole words only, always at even addresses.
module crli_linkage #(
    parameter logic [15:0] SP_RESET = `CRLI_SP_RST
) (
    input  wire logic             mclk_in,
    input  wire logic             srst_in,
    input  wire logic             irq_req_in,
    input  wire crli_pkg::crli_word_t irq_vector_in,
    output logic                  irq_ack_out,
    input  wire logic             boundary_in,
    input  wire logic             op_valid_in,
    input  wire crli_pkg::crli_op_t op_in,
    input  wire logic [2:0]       op_reg_in,
    input  wire crli_pkg::crli_word_t op_dest_in,
    output logic                  op_ready_out,
    input  wire logic             seq_wr_en_in,
    input  wire logic [2:0]       seq_wr_idx_in,
    input  wire crli_pkg::crli_word_t seq_wr_data_in,
    output logic                  busy_out,
    output crli_pkg::crli_word_t  pc_out,
    output crli_pkg::crli_word_t  sp_out,
    output crli_pkg::crli_word_t  psw_out,
    output logic [1:0]            psw_mode_out,
    output logic                  psw_regset_out,
    output logic                  mem_req_out,
    output logic                  mem_we_out,
    output crli_pkg::crli_word_t  mem_addr_out,
    output crli_pkg::crli_word_t  mem_wdata_out,
    input  wire logic             mem_ack_in,
    input  wire crli_pkg::crli_word_t mem_rdata_in
);
    import crli_pkg::*;

    generate
        if (SP_RESET[0] != 1'b0) begin : g_bad_sp
            $error("SP_RESET must be even");
        end
    endgenerate

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    crli_state_t state_reg, state_next;
    crli_word_t  addr_reg, addr_next, wdata_reg, wdata_next;
    crli_word_t  dest_reg, vec_reg, psw_reg, psw_next;
    logic [2:0]  idx_reg;
    logic        we_reg, we_next, ack_reg, irq_meta_reg, irq_sync_reg;

    crli_rf_if rf ();
    crli_regfile #(.SP_RESET(SP_RESET)) u_regs (
        .mclk_in (mclk_in),
        .srst_in (srst_in),
        .rf      (rf.store)
    );

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire crli_word_t sp_w     = rf.regs[`CRLI_SP_IDX];
    wire crli_word_t pc_w     = rf.regs[`CRLI_PC_IDX];
    wire crli_word_t link_w   = rf.regs[op_reg_in];
    wire crli_word_t sp_dec_w = sp_w - `CRLI_WORD_STEP;
    wire crli_word_t sp_inc_w = sp_w + `CRLI_WORD_STEP;
    wire logic idle_w     = (state_reg == CRLI_ST_IDLE);
    wire logic take_irq_w = idle_w && irq_sync_reg && boundary_in;
    wire logic take_op_w  = idle_w && op_valid_in && !take_irq_w;

    assign op_ready_out   = idle_w && !take_irq_w;
    assign busy_out       = !idle_w;
    assign mem_req_out    = !idle_w;
    assign mem_we_out     = we_reg;
    assign mem_addr_out   = addr_reg;
    assign mem_wdata_out  = wdata_reg;
    assign irq_ack_out    = ack_reg;
    assign pc_out         = pc_w;
    assign sp_out         = sp_w;
    assign psw_out        = psw_reg;
    assign psw_mode_out   = psw_reg[`CRLI_PSW_MODE_HI:`CRLI_PSW_MODE_LO];
    assign psw_regset_out = psw_reg[`CRLI_PSW_RSET];

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        we_next    = we_reg;
        psw_next   = psw_reg;
        rf.pc_we   = 1'b0;
        rf.pc_d    = pc_w;
        rf.sp_we   = 1'b0;
        rf.sp_d    = sp_w;
        rf.gen_we  = 1'b0;
        rf.gen_idx = seq_wr_idx_in;
        rf.gen_d   = seq_wr_data_in;
        case (state_reg)
            CRLI_ST_IDLE: begin
                if (take_irq_w) begin
                    rf.sp_we   = 1'b1;
                    rf.sp_d    = sp_dec_w;
                    addr_next  = sp_dec_w & `CRLI_EVEN_MASK;
                    wdata_next = psw_reg;
                    we_next    = 1'b1;
                    state_next = CRLI_ST_INT_PSW;
                end else if (take_op_w && op_in == CRLI_OP_CALL) begin
                    rf.sp_we   = 1'b1;
                    rf.sp_d    = sp_dec_w;
                    addr_next  = sp_dec_w & `CRLI_EVEN_MASK;
                    wdata_next = link_w;
                    we_next    = 1'b1;
                    state_next = CRLI_ST_CALL_PUSH;
                end else if (take_op_w && op_in == CRLI_OP_RET) begin
                    rf.pc_we   = 1'b1;
                    rf.pc_d    = link_w;
                    addr_next  = sp_w & `CRLI_EVEN_MASK;
                    we_next    = 1'b0;
                    state_next = CRLI_ST_RET_POP;
                end else if (take_op_w && op_in == CRLI_OP_RTI) begin
                    addr_next  = sp_w & `CRLI_EVEN_MASK;
                    we_next    = 1'b0;
                    state_next = CRLI_ST_RTI_PC;
                end else begin
                    rf.gen_we  = seq_wr_en_in;
                end
            end
            CRLI_ST_CALL_PUSH: begin
                if (mem_ack_in) begin
                    rf.gen_we  = 1'b1;
                    rf.gen_idx = idx_reg;
                    rf.gen_d   = pc_w;
                    rf.pc_we   = 1'b1;
                    rf.pc_d    = dest_reg;
                    state_next = CRLI_ST_IDLE;
                end
            end
            CRLI_ST_RET_POP: begin
                if (mem_ack_in) begin
                    rf.gen_we  = 1'b1;
                    rf.gen_idx = idx_reg;
                    rf.gen_d   = mem_rdata_in;
                    rf.sp_we   = (idx_reg != `CRLI_SP_IDX);
                    rf.sp_d    = sp_inc_w;
                    rf.pc_we   = (idx_reg == `CRLI_PC_IDX);
                    rf.pc_d    = mem_rdata_in;
                    state_next = CRLI_ST_IDLE;
                end
            end
            CRLI_ST_INT_PSW: begin
                if (mem_ack_in) begin
                    rf.sp_we   = 1'b1;
                    rf.sp_d    = sp_dec_w;
                    addr_next  = sp_dec_w & `CRLI_EVEN_MASK;
                    wdata_next = pc_w;
                    state_next = CRLI_ST_INT_PC;
                end
            end
            CRLI_ST_INT_PC: begin
                if (mem_ack_in) begin
                    addr_next  = vec_reg;
                    we_next    = 1'b0;
                    state_next = CRLI_ST_VEC_PC;
                end
            end
            CRLI_ST_VEC_PC: begin
                if (mem_ack_in) begin
                    rf.pc_we   = 1'b1;
                    rf.pc_d    = mem_rdata_in;
                    addr_next  = vec_reg + `CRLI_WORD_STEP;
                    state_next = CRLI_ST_VEC_PSW;
                end
            end
            CRLI_ST_VEC_PSW: begin
                if (mem_ack_in) begin
                    psw_next   = mem_rdata_in;
                    state_next = CRLI_ST_IDLE;
                end
            end
            CRLI_ST_RTI_PC: begin
                if (mem_ack_in) begin
                    rf.pc_we   = 1'b1;
                    rf.pc_d    = mem_rdata_in;
                    rf.sp_we   = 1'b1;
                    rf.sp_d    = sp_inc_w;
                    addr_next  = sp_inc_w & `CRLI_EVEN_MASK;
                    state_next = CRLI_ST_RTI_PSW;
                end
            end
            CRLI_ST_RTI_PSW: begin
                if (mem_ack_in) begin
                    psw_next   = mem_rdata_in;
                    rf.sp_we   = 1'b1;
                    rf.sp_d    = sp_inc_w;
                    state_next = CRLI_ST_IDLE;
                end
            end
            default: begin
                state_next = CRLI_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Flops
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            irq_meta_reg <= 1'b0;
            irq_sync_reg <= 1'b0;
        end else begin
            irq_meta_reg <= irq_req_in;
            irq_sync_reg <= irq_meta_reg;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_reg <= CRLI_ST_IDLE;
            addr_reg  <= 16'h0000;
            wdata_reg <= 16'h0000;
            we_reg    <= 1'b0;
            psw_reg   <= `CRLI_PSW_RST;
            ack_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            we_reg    <= we_next;
            psw_reg   <= psw_next;
            ack_reg   <= take_irq_w;
        end
    end

    // Operands latched at acceptance so the sequencer may move on
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            idx_reg  <= 3'h0;
            dest_reg <= 16'h0000;
            vec_reg  <= 16'h0000;
        end else if (idle_w) begin
            idx_reg  <= op_reg_in;
            dest_reg <= op_dest_in;
            vec_reg  <= irq_vector_in & `CRLI_EVEN_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    a_sp_even_word: assert property (sp_w[0] == 1'b0)
        else $error("stack pointer odd");
    a_call_pre_dec: assert property (take_op_w && op_in == CRLI_OP_CALL |=>
        sp_w == $past(sp_w) - 16'h0002 && mem_addr_out == sp_w && mem_wdata_out == $past(link_w))
        else $error("call push wrong");
    a_call_link_pc: assert property (state_reg == CRLI_ST_CALL_PUSH && mem_ack_in
        && idx_reg != 3'h7 |=> pc_w == $past(dest_reg) && rf.regs[$past(idx_reg)] == $past(pc_w))
        else $error("call linkage wrong");
    a_ret_copy_pc: assert property (take_op_w && op_in == CRLI_OP_RET |=>
        pc_w == $past(link_w) && state_reg == CRLI_ST_RET_POP)
        else $error("return pc wrong");
    a_irq_boundary: assert property (irq_ack_out |-> $past(boundary_in) && $past(idle_w))
        else $error("interrupt taken off boundary");
    a_int_push_order: assert property (take_irq_w |=> state_reg == CRLI_ST_INT_PSW
        && mem_we_out && mem_wdata_out == $past(psw_reg))
        else $error("interrupt status push wrong");
    a_int_push_pc: assert property (state_reg == CRLI_ST_INT_PSW && mem_ack_in |=>
        state_reg == CRLI_ST_INT_PC && mem_we_out && mem_wdata_out == $past(pc_w))
        else $error("interrupt pc push wrong");
    a_vec_words: assert property (state_reg == CRLI_ST_VEC_PC && mem_ack_in |=>
        pc_w == $past(mem_rdata_in) && mem_addr_out == vec_reg + 16'h0002)
        else $error("vector fetch wrong");
    a_psw_mode_load: assert property (state_reg == CRLI_ST_VEC_PSW && mem_ack_in |=>
        psw_mode_out == $past(mem_rdata_in[15:14]) && idle_w)
        else $error("status load wrong");
    a_rti_pop_pair: assert property (state_reg == CRLI_ST_RTI_PC && mem_ack_in |=>
        pc_w == $past(mem_rdata_in) && sp_w == $past(sp_w) + 16'h0002)
        else $error("return from interrupt pop wrong");
    a_push_uses_sp: assert property (mem_req_out && mem_we_out |-> mem_addr_out == sp_w)
        else $error("push not at stack pointer");
    a_pop_post_inc: assert property (state_reg == CRLI_ST_RTI_PSW && mem_ack_in |=>
        sp_w == $past(sp_w) + 16'h0002)
        else $error("pop increment wrong");
endmodule : crli_linkage
`default_nettype wire

// ==== tb/crli_periph_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module crli_periph_model #(
    parameter logic [15:0] VECTOR = 16'h0060
) (
    input  wire logic            mclk_in,
    input  wire logic            srst_in,
    input  wire logic            set_done_in,
    input  wire logic            irq_ack_in,
    output logic                 irq_req_out,
    output crli_pkg::crli_word_t vector_out
);
    import crli_pkg::*;
    logic [15:0] csr_reg;
    // ------------------------------------------------------------------
    // Done flag, cleared by acknowledge
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            csr_reg <= 16'h0000;
        end else if (irq_ack_in) begin
            csr_reg[7] <= 1'b0;
        end else if (set_done_in) begin
            csr_reg[7] <= 1'b1;
        end
    end
    assign irq_req_out = csr_reg[7];
    // Garbage off request so a late latch shows up
    assign vector_out  = csr_reg[7] ? VECTOR : ~VECTOR;
endmodule : crli_periph_model
`default_nettype wire

// ==== tb/call_return_interrupt_linkage_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "crli_consts.svh"
module call_return_interrupt_linkage_tb;
    import crli_pkg::*;
    localparam logic [15:0] VEC = 16'h0060;
    logic        mclk_in, srst_in, boundary_in, op_valid_in, seq_wr_en_in, mem_ack_in;
    logic        set_done, irq_req, irq_ack_out, op_ready_out, busy_out, psw_regset_out;
    logic        mem_req_out, mem_we_out;
    logic [1:0]  psw_mode_out;
    logic [2:0]  op_reg_in, seq_wr_idx_in;
    crli_op_t    op_in;
    crli_word_t  vec, op_dest_in, seq_wr_data_in, pc_out, sp_out, psw_out;
    crli_word_t  mem_addr_out, mem_wdata_out, mem_rdata_in;
    logic [15:0] mem [0:32767];
    logic [15:0] mm [int];
    logic [15:0] m_reg [8];
    logic [15:0] m_psw;
    integer      seed, fail_count, checks;
    int          stk [$];

    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end

    crli_periph_model #(.VECTOR(VEC)) periph_u (.mclk_in(mclk_in), .srst_in(srst_in),
        .set_done_in(set_done), .irq_ack_in(irq_ack_out), .irq_req_out(irq_req),
        .vector_out(vec));

    crli_linkage dut_u (.mclk_in(mclk_in), .srst_in(srst_in), .irq_req_in(irq_req),
        .irq_vector_in(vec), .irq_ack_out(irq_ack_out), .boundary_in(boundary_in),
        .op_valid_in(op_valid_in), .op_in(op_in), .op_reg_in(op_reg_in),
        .op_dest_in(op_dest_in), .op_ready_out(op_ready_out), .seq_wr_en_in(seq_wr_en_in),
        .seq_wr_idx_in(seq_wr_idx_in), .seq_wr_data_in(seq_wr_data_in),
        .busy_out(busy_out), .pc_out(pc_out), .sp_out(sp_out), .psw_out(psw_out),
        .psw_mode_out(psw_mode_out), .psw_regset_out(psw_regset_out),
        .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .mem_ack_in(mem_ack_in), .mem_rdata_in(mem_rdata_in));

    // ------------------------------------------------------------------
    // Memory with random stalls
    // ------------------------------------------------------------------
    always @(posedge mclk_in) begin
        mem_ack_in   <= mem_req_out && !mem_ack_in && (($random(seed) & 3) != 0);
        mem_rdata_in <= mem_req_out ? mem[mem_addr_out[15:1]] : ~mem_rdata_in;
        if (mem_ack_in && mem_req_out) begin
            check("mem_addr_bit0", {15'h0000, mem_addr_out[0]}, 16'h0000);
            if (mem_we_out) begin
                mem[mem_addr_out[15:1]] <= mem_wdata_out;
            end
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic timeout(input string what);
        fail_count = fail_count + 1;
        $display("Error %s expected done seen timeout", what);
        end_sim();
    endtask : timeout

    task automatic wait_idle();
        int n;
        @(negedge mclk_in);
        for (n = 0; n < 200 && busy_out !== 1'b0; n++) @(negedge mclk_in);
        if (n == 200) timeout("busy_out");
    endtask : wait_idle

    task automatic poke(input logic [15:0] a, input logic [15:0] d);
        mem[a[15:1]] = d;
        mm[a]        = d;
    endtask : poke

    task automatic cmp_state();
        check("pc_out", pc_out, m_reg[7]);
        check("sp_out", sp_out, m_reg[6]);
        check("psw_out", psw_out, m_psw);
        check("psw_mode_out", {14'h0000, psw_mode_out}, {14'h0000, m_psw[15:14]});
        check("psw_regset_out", {15'h0000, psw_regset_out}, {15'h0000, m_psw[11]});
        if (mm.exists(m_reg[6])) check("stack_top", mem[m_reg[6][15:1]], mm[m_reg[6]]);
    endtask : cmp_state

    task automatic wr(input logic [2:0] idx, input logic [15:0] d);
        @(posedge mclk_in);
        seq_wr_en_in   <= 1'b1;
        seq_wr_idx_in  <= idx;
        seq_wr_data_in <= d;
        @(posedge mclk_in);
        seq_wr_en_in   <= 1'b0;
        m_reg[idx]      = d;
    endtask : wr

    task automatic do_op(input crli_op_t op, input logic [2:0] r, input logic [15:0] dest);
        int n;
        @(posedge mclk_in);
        op_valid_in <= 1'b1;
        op_in       <= op;
        op_reg_in   <= r;
        op_dest_in  <= dest;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk_in);
            if (op_ready_out === 1'b1) break;
        end
        op_valid_in <= 1'b0;
        if (n == 20) timeout("op_ready_out");
        if (op == CRLI_OP_CALL) begin
            m_reg[6]     = m_reg[6] - 16'h0002;
            mm[m_reg[6]] = m_reg[r];
            m_reg[r]     = m_reg[7];
            m_reg[7]     = dest;
        end else if (op == CRLI_OP_RET) begin
            m_reg[7] = m_reg[r];
            m_reg[r] = mm[m_reg[6]];
            m_reg[6] = m_reg[6] + 16'h0002;
        end else begin
            m_reg[7] = mm[m_reg[6]];
            m_psw    = mm[m_reg[6] + 16'h0002];
            m_reg[6] = m_reg[6] + 16'h0004;
        end
        wait_idle();
        cmp_state();
    endtask : do_op

    task automatic irq(input logic [15:0] new_pc, input logic [15:0] new_psw);
        int n;
        int acks;
        poke(VEC, new_pc);
        poke(VEC + 16'h0002, new_psw);
        acks = 0;
        @(posedge mclk_in);
        boundary_in <= 1'b0;
        set_done    <= 1'b1;
        @(posedge mclk_in);
        set_done    <= 1'b0;
        repeat (6) begin
            @(posedge mclk_in);
            acks = acks + int'(irq_ack_out === 1'b1);
        end
        check("ack_off_boundary", acks[15:0], 16'h0000);
        boundary_in <= 1'b1;
        for (n = 0; n < 20 && irq_ack_out !== 1'b1; n++) @(posedge mclk_in);
        if (n == 20) timeout("irq_ack_out");
        m_reg[6]     = m_reg[6] - 16'h0002;
        mm[m_reg[6]] = m_psw;
        m_reg[6]     = m_reg[6] - 16'h0002;
        mm[m_reg[6]] = m_reg[7];
        m_reg[7]     = new_pc;
        m_psw        = new_psw;
        wait_idle();
        cmp_state();
        check("saved_psw", mem[m_reg[6][15:1] + 15'h0001], mm[m_reg[6] + 16'h0002]);
    endtask : irq

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'h4b36838d;
        fail_count = 0;
        checks = 0;
        {srst_in, boundary_in, op_valid_in, seq_wr_en_in, set_done} = 5'b11000;
        op_in = CRLI_OP_CALL;
        {op_reg_in, seq_wr_idx_in} = 6'h00;
        {op_dest_in, seq_wr_data_in} = 32'h0;
        foreach (m_reg[i]) m_reg[i] = 16'h0000;
        m_reg[6] = `CRLI_SP_RST;
        m_psw = `CRLI_PSW_RST;
        repeat (5) @(posedge mclk_in);
        srst_in <= 1'b0;
        @(negedge mclk_in);
        cmp_state();
        $display("test reset done");
        wr(3'h5, 16'h1234);
        wr(3'h7, 16'h0200);
        do_op(CRLI_OP_CALL, 3'h5, 16'h0434);
        do_op(CRLI_OP_CALL, 3'h7, 16'h0600);
        do_op(CRLI_OP_RET, 3'h7, 16'h0000);
        do_op(CRLI_OP_RET, 3'h5, 16'h0000);
        do_op(CRLI_OP_CALL, 3'h5, 16'h0100);
        $display("test call_return done");
        irq(16'h3000, 16'hc800);
        irq(16'h3400, 16'h4000);
        do_op(CRLI_OP_RTI, 3'h0, 16'h0000);
        do_op(CRLI_OP_RTI, 3'h0, 16'h0000);
        $display("test interrupt done");
        for (int r = 0; r < 6; r++) wr(r[2:0], 16'($random(seed)));
        for (int i = 0; i < 40; i++) begin
            if (stk.size() > 0 && ($random(seed) & 1)) begin
                do_op(CRLI_OP_RET, 3'(stk.pop_back()), 16'h0000);
            end else begin
                stk.push_back(($random(seed) & 7) == 6 ? 7 : ($random(seed) & 7) % 6);
                do_op(CRLI_OP_CALL, 3'(stk[$]), 16'($random(seed)) & `CRLI_EVEN_MASK);
            end
        end
        $display("test random_nesting done");
        end_sim();
    end
endmodule : call_return_interrupt_linkage_tb
`default_nettype wire
